// File: test_watchdog_with_address_trap.sv
/*
 * Self-checking bench: APB tasks, CPU model and checker around wdat_top.
 * Assumes wdat_top, wdat_cpu_model and wdat_props are compiled first.
 */
`timescale 1ns/1ps
`include "wdat_map.vh"

module test_watchdog_with_address_trap;
    logic        ref_clk, rst, psel, penable, pwrite, low_speed_mode_one;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, fetch_valid, irq_ack, er, hw_q;
    logic [15:0] fetch_addr;
    logic        watchdog_irq, fetch_trap_irq, hw_reset_req, osc_restart;
    int          fail_count = 0;
    int          check_count = 0;
    int          rises = 0;

    // Short prescaler keeps overflow near 64 cycles
    wdat_top #(.PRE_W(4)) wdat_top_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .low_speed_mode_one(low_speed_mode_one), .irq_ack(irq_ack),
        .watchdog_irq(watchdog_irq), .fetch_trap_irq(fetch_trap_irq),
        .hw_reset_req(hw_reset_req), .osc_restart(osc_restart));
    wdat_cpu_model wdat_cpu_model_inst (.ref_clk(ref_clk), .watchdog_irq(watchdog_irq),
        .fetch_trap_irq(fetch_trap_irq), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .irq_ack(irq_ack));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Counts reset request rising edges
    always @(posedge ref_clk) begin
        hw_q <= hw_reset_req;
        if (hw_reset_req && !hw_q)
            rises++;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task summarize();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge ref_clk);
        if (k == 20) begin
            fail_count++;
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    // Waits for a reset request, then measures how long it stands
    task wait_hw();
        int k;
        int n;
        k = 0;
        n = 0;
        while (hw_reset_req !== 1'b1 && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        chk(k < 3000, 1);
        if (k == 3000)
            summarize();
        chk(osc_restart, low_speed_mode_one);
        while (hw_reset_req === 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n, 24);
        if (n == 40)
            summarize();
    endtask

    task wait_wd(input int exp);
        int k;
        for (k = 0; k < 3000 && wdat_cpu_model_inst.wd_cnt != exp; k++)
            @(posedge ref_clk);
        chk(wdat_cpu_model_inst.wd_cnt, exp);
        if (k == 3000)
            summarize();
    endtask

    task do_rst();
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
    endtask

    // Guarded stop sequence with the given control value
    task off(input logic [7:0] c);
        wdat_cpu_model_inst.interrupt_master_flag = 1'b0;
        wr(`WDAT_OFF_CMD, `WDAT_CODE_CLEAR);
        wr(`WDAT_OFF_CTRL, c);
        wr(`WDAT_OFF_CMD, `WDAT_CODE_DISABLE);
    endtask

    // Trap result is in the model count four edges after the fetch
    task trap(input logic [15:0] a, input logic i, input int exp);
        wdat_cpu_model_inst.fetch(a, i);
        repeat (4) @(posedge ref_clk);
        chk(wdat_cpu_model_inst.trap_cnt, exp);
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        low_speed_mode_one = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, `WDAT_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `WDAT_OFF_CMD, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(er, 1'b1);
        low_speed_mode_one <= 1'b1;
        wr(`WDAT_OFF_CMD, `WDAT_CODE_DISABLE);
        wait_hw();
        low_speed_mode_one <= 1'b0;
        do_rst();
        repeat (8) begin
            wr(`WDAT_OFF_CMD, `WDAT_CODE_CLEAR);
            repeat (20) @(posedge ref_clk);
        end
        chk(rises, 1);
        off(8'h31);
        repeat (200) @(posedge ref_clk);
        chk(rises, 1);
        wdat_cpu_model_inst.fetch(16'h0010, 1'b1);
        wait_hw();
        do_rst();
        wdat_cpu_model_inst.load_sp();
        off(8'h21);
        wr(`WDAT_OFF_CMD, `WDAT_CODE_TRAPSEL);
        trap(16'h0010, 1'b0, 0);
        trap(16'h0100, 1'b1, 1);
        trap(16'h0f90, 1'b1, 2);
        chk(wdat_cpu_model_inst.depth, 2);
        wr(`WDAT_OFF_CTRL, 8'h01);
        trap(16'h0100, 1'b1, 3);
        wr(`WDAT_OFF_CMD, `WDAT_CODE_TRAPSEL);
        trap(16'h0100, 1'b1, 3);
        trap(16'h0020, 1'b1, 4);
        wdat_cpu_model_inst.ret_irq();
        wdat_cpu_model_inst.load_sp();
        wr(`WDAT_OFF_CTRL, 8'h08);
        wait_wd(1);
        wr(`WDAT_OFF_CTRL, 8'h09);
        wait_wd(2);
        chk(rises, 2);
        chk(wdat_cpu_model_inst.irq_no_sp, 1'b0);
        summarize();
    end
endmodule // test_watchdog_with_address_trap

bind wdat_top wdat_props #(.AW(AW), .SFR_LO(SFR_LO), .SFR_HI(SFR_HI), .DBR_LO(DBR_LO),
    .DBR_HI(DBR_HI)) wdat_props_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .low_speed_mode_one(low_speed_mode_one), .watchdog_irq(watchdog_irq),
    .fetch_trap_irq(fetch_trap_irq), .hw_reset_req(hw_reset_req), .osc_restart(osc_restart));

// File: wdat_cpu_model.sv
/*
 * CPU core stand-in: instruction fetch strobes and nonmaskable nesting.
 * Assumes the bench calls its tasks; signals change after rising edges.
 */
`timescale 1ns/1ps

module wdat_cpu_model (
    input  wire logic        ref_clk,
    input  wire logic        watchdog_irq,
    input  wire logic        fetch_trap_irq,
    output logic             fetch_valid,
    output logic [15:0]      fetch_addr,
    output logic             irq_ack
);
    int wd_cnt   = 0;
    int trap_cnt = 0;
    int depth    = 0;
    bit sp_ok    = 0;
    bit interrupt_master_flag      = 1;
    bit irq_no_sp = 0;

    initial begin
        fetch_valid = 1'b0;
        fetch_addr  = 16'hffff;
        irq_ack     = 1'b0;
    end

    // Every request is taken at once, the one in service stays pending
    always @(posedge ref_clk) begin
        wd_cnt   <= wd_cnt + watchdog_irq;
        trap_cnt <= trap_cnt + fetch_trap_irq;
        depth    <= depth + watchdog_irq + fetch_trap_irq - irq_ack;
        // An interrupt taken with no stack set up would corrupt memory
        if ((watchdog_irq || fetch_trap_irq) && !sp_ok)
            irq_no_sp <= 1'b1;
    end

    // One-cycle fetch; released bus shows the inverse, never a stale address
    task fetch(input logic [15:0] a, input logic instr);
        @(posedge ref_clk);
        fetch_valid <= instr;
        fetch_addr  <= a;
        @(posedge ref_clk);
        fetch_valid <= 1'b0;
        fetch_addr  <= ~a;
    endtask

    // Return from a nonmaskable handler
    task ret_irq();
        @(posedge ref_clk);
        irq_ack <= 1'b1;
        @(posedge ref_clk);
        irq_ack <= 1'b0;
    endtask

    // Stack must be valid before any interrupt mode is chosen
    task load_sp();
        sp_ok = 1'b1;
    endtask
endmodule // wdat_cpu_model

// File: wdat_map.vh
/*
 * Register offsets, field positions, reset values, command codes and
 * timing counts for the watchdog with fetch-address trap.
 * Assumes a 32-bit APB slave decoding byte addresses.
 */
`ifndef WDAT_MAP_VH
`define WDAT_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WDAT_OFF_CTRL     12'h000
`define WDAT_OFF_CMD      12'h004
`define WDAT_OFF_STAT     12'h008
`define WDAT_OFF_AREA     12'h00c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define WDAT_CTRL_OUT     0
`define WDAT_CTRL_TT_LO   1
`define WDAT_CTRL_TT_HI   2
`define WDAT_CTRL_EN      3
`define WDAT_CTRL_TRAP_ACTION_SELECT   4
`define WDAT_CTRL_RAM_TRAP_SELECT    5
`define WDAT_CTRL_RESET   8'h39

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define WDAT_CODE_TRAPSEL 8'hd2
`define WDAT_CODE_CLEAR   8'h4e
`define WDAT_CODE_DISABLE 8'hb1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WDAT_CLK_HZ       20000000
`define WDAT_RST_FC_PER   24
`define WDAT_RST_CYC      ((`WDAT_RST_FC_PER * 1) > 0 ? `WDAT_RST_FC_PER : 1)

`endif

// File: wdat_props.sv
/*
 * Port checker for wdat_top: trap latency, reset pulse length, pulses.
 * Assumes a bind to wdat_top, ref_clk the only clock, rst async high.
 */
`timescale 1ns/1ps
`include "wdat_map.vh"

module wdat_props #(
    parameter        AW     = 16,
    parameter [15:0] SFR_LO = 16'h0000,
    parameter [15:0] SFR_HI = 16'h003f,
    parameter [15:0] DBR_LO = 16'h0f80,
    parameter [15:0] DBR_HI = 16'h0fff
) (
    input wire logic          ref_clk,
    input wire logic          rst,
    input wire logic          ce,
    input wire logic          psel,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          fetch_valid,
    input wire logic [AW-1:0] fetch_addr,
    input wire logic          low_speed_mode_one,
    input wire logic          watchdog_irq,
    input wire logic          fetch_trap_irq,
    input wire logic          hw_reset_req,
    input wire logic          osc_restart
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [5:0] hw_len_r;
    wire        hot_fetch = fetch_valid && ce &&
                ((fetch_addr >= SFR_LO && fetch_addr <= SFR_HI) ||
                 (fetch_addr >= DBR_LO && fetch_addr <= DBR_HI));

    // Run length of the reset request; saturates well past the limit
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            hw_len_r <= 6'd0;
        else if (hw_reset_req && hw_len_r != 6'h3f)
            hw_len_r <= hw_len_r + 6'd1;
        else if (!hw_reset_req)
            hw_len_r <= 6'd0;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_trap_area_lat: assert property (hot_fetch |-> ##2 (fetch_trap_irq || hw_reset_req))
        else $error("area fetch not trapped two cycles later");
    a_trap_from_fetch: assert property (fetch_trap_irq |-> $past(fetch_valid, 2))
        else $error("trap irq without an instruction fetch");
    a_reset_exact_len: assert property ($fell(hw_reset_req) |-> hw_len_r == 6'd24)
        else $error("reset request length not 24 cycles");
    a_reset_max_len: assert property (hw_len_r <= 6'd24)
        else $error("reset request longer than 24 cycles");
    a_osc_low_speed: assert property ($rose(hw_reset_req) && low_speed_mode_one |-> osc_restart)
        else $error("oscillator restart missing in low speed");
    a_osc_with_reset: assert property (osc_restart |-> hw_reset_req)
        else $error("oscillator restart outside reset");
    a_wd_irq_pulse: assert property (watchdog_irq |=> !watchdog_irq)
        else $error("watchdog irq wider than one cycle");
    a_cmd_write_only: assert property (pready && psel && !pwrite && paddr == `WDAT_OFF_CMD
        |-> prdata == 32'h0)
        else $error("command register read not zero");
    a_ctrl_write_only: assert property (pready && psel && !pwrite && paddr == `WDAT_OFF_CTRL
        |-> prdata == 32'h0)
        else $error("control register read not zero");

    c_hw_reset: cover property ($rose(hw_reset_req));
    c_trap_irq: cover property (fetch_trap_irq);
    c_wd_irq:   cover property (watchdog_irq);
endmodule // wdat_props

// File: wdat_top.v
/*
 * Watchdog timer with fetch-address trap, behind an APB slave.
 * Assumes the CPU presents fetch addresses with a one-cycle strobe and
 * that all inputs are synchronous to ref_clk.
 */
// Decided for this implementation: the register offsets and the APB interface to the registers.
// What the document requires
// R1: Software disables via clear, enable-off, disable code
// R2: Counters held zero while disabled
// R3: Command write-only; D2H, 4EH, B1H decoded
// R4: Overflow action 0 raises watchdog interrupt
// R5: Watchdog interrupt ignores interrupt master flag
// R6: New watchdog interrupt preempts; earlier held pending
// R7: Software loads stack pointer before interrupt mode
// R8: Overflow action 1 issues watchdog reset
// R9: Watchdog reset lasts at most 24 periods; here an overflow or trap while it stands reloads the count for 24 more
// R10: Low-speed mode reset restarts oscillator, same bound
// R11: Trap controls share the watchdog control registers
// R12: RAM trap select applies only after D2H
// R13: Register and buffer area fetches always trap
// R14: Trap action 0 raises trap interrupt
// R15: Trap action 1 raises trap reset
// R16: Trap interrupt ignores interrupt master flag
// R17: New trap interrupt preempts; earlier held pending
// R18: Trap reset lasts at most 24 periods; here a trap or overflow while it stands reloads the count for 24 more
// R19: Software sets stack pointer before trap interrupts
// R20: Overflow action cannot return to 1
// R21: Disable code honoured only with enable 0
// R22: Enable bit resets to 1
// R23: Software clears within 3/4 detection time
// R24: Only instruction fetches are compared
`timescale 1ns/1ps
`include "wdat_map.vh"

module wdat_top #(
    parameter        AW       = 16,
    parameter        PRE_W    = 17,
    parameter [15:0] SFR_LO   = 16'h0000,
    parameter [15:0] SFR_HI   = 16'h003f,
    parameter [15:0] RAM_LO   = 16'h0040,
    parameter [15:0] RAM_HI   = 16'h043f,
    parameter [15:0] DBR_LO   = 16'h0f80,
    parameter [15:0] DBR_HI   = 16'h0fff
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire          ce,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire          fetch_valid,
    input  wire [AW-1:0] fetch_addr,
    input  wire          low_speed_mode_one,
    input  wire          irq_ack,
    output reg           watchdog_irq,
    output reg           fetch_trap_irq,
    output reg           hw_reset_req,
    output reg           osc_restart
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg             en_r;          // watchdog enable
    reg             out_r;         // overflow action select
    reg  [1:0]      tt_r;          // detection time select
    reg             trap_action_select_r;       // trap action select
    reg             ram_trap_select_wr_r;     // ram trap select, as written
    reg             ram_trap_select_r;        // ram trap select, in effect
    reg  [PRE_W-1:0] pre_r;        // prescaler, not cleared by the clear code
    reg  [1:0]      bin_r;         // two-stage binary counter
    reg  [4:0]      rst_cnt_r;
    reg  [7:0]      wd_pend_r;     // pending nest depth, watchdog
    reg  [7:0]      at_pend_r;     // pending nest depth, trap
    reg             ovf_seen_r;
    reg             trap_seen_r;
    reg             apb_done_r;
    reg             pend_en_r;     // enable as last written
    wire            hit_sfr;
    wire            hit_ram;
    wire            hit_dbr;
    wire            fetch_ok;
    wire            setup;
    wire            wr;
    wire            tick;
    wire            ovf;
    wire            trap;
    wire [7:0]      wcode;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign setup = psel && penable && !apb_done_r;
    assign wr    = setup && pwrite;
    assign wcode = pwdata[7:0];

    // Prescaler tap: larger select value means a shorter detection time
    // Each select step shifts the tap by two bits, a quarter of the time
    assign tick = en_r && (pre_r == ({PRE_W{1'b1}} >> {tt_r, 1'b0}));
    assign ovf  = tick && (bin_r == 2'b11);

    // ------------------------------------------------------------------
    // Area comparators
    // ------------------------------------------------------------------
    // Only the fetch strobe qualifies a compare; data cycles never trap
    assign fetch_ok = fetch_valid; // R24

    wdat_trap_cmp #(.AW(AW)) u_sfr (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .on      (fetch_ok),
        .addr    (fetch_addr),
        .lo      (SFR_LO[AW-1:0]),
        .hi      (SFR_HI[AW-1:0]),
        .hit_r   (hit_sfr)
    );

    wdat_trap_cmp #(.AW(AW)) u_dbr (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .on      (fetch_ok),
        .addr    (fetch_addr),
        .lo      (DBR_LO[AW-1:0]),
        .hi      (DBR_HI[AW-1:0]),
        .hit_r   (hit_dbr)
    );

    wdat_trap_cmp #(.AW(AW)) u_ram (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .on      (fetch_ok && ram_trap_select_r), // R12
        .addr    (fetch_addr),
        .lo      (RAM_LO[AW-1:0]),
        .hi      (RAM_HI[AW-1:0]),
        .hit_r   (hit_ram)
    );

    // Register and buffer areas trap regardless of the RAM select
    assign trap = hit_sfr || hit_dbr || hit_ram; // R13

    // ------------------------------------------------------------------
    // Control and command registers
    // ------------------------------------------------------------------
    // Control and trap bits share one register word
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_r      <= 1'b1; // R22
            out_r     <= 1'b1;
            tt_r      <= 2'b00;
            trap_action_select_r   <= 1'b1;
            ram_trap_select_wr_r <= 1'b1;
            ram_trap_select_r    <= 1'b1;
        end else if (ce) begin
            if (wr && paddr == `WDAT_OFF_CTRL) begin
                tt_r      <= pwdata[`WDAT_CTRL_TT_HI:`WDAT_CTRL_TT_LO];
                out_r     <= out_r & pwdata[`WDAT_CTRL_OUT]; // R20
                trap_action_select_r   <= pwdata[`WDAT_CTRL_TRAP_ACTION_SELECT]; // R11
                ram_trap_select_wr_r <= pwdata[`WDAT_CTRL_RAM_TRAP_SELECT];
                // Clearing the enable takes effect only with the disable code
                if (pwdata[`WDAT_CTRL_EN]) begin
                    en_r <= 1'b1;
                end
            end
            if (wr && paddr == `WDAT_OFF_CMD) begin
                case (wcode) // R3
                    `WDAT_CODE_TRAPSEL: ram_trap_select_r <= ram_trap_select_wr_r; // R12
                    `WDAT_CODE_DISABLE: begin
                        if (!pend_en_r) begin
                            en_r <= 1'b0; // R21
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Written enable value waits for the disable code
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_en_r <= 1'b1;
        end else if (ce && wr && paddr == `WDAT_OFF_CTRL) begin
            pend_en_r <= pwdata[`WDAT_CTRL_EN];
        end
    end

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    // Clear code resets only the binary stage, so overflow may come at 3/4
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_r <= {PRE_W{1'b0}};
            bin_r <= 2'b00;
        end else if (ce) begin
            if (!en_r) begin
                pre_r <= {PRE_W{1'b0}}; // R2
                bin_r <= 2'b00;         // R2
            end else begin
                pre_r <= tick ? {PRE_W{1'b0}} : pre_r + 1'b1;
                if (wr && paddr == `WDAT_OFF_CMD && wcode == `WDAT_CODE_CLEAR) begin
                    bin_r <= 2'b00; // R23
                end else if (tick) begin
                    bin_r <= bin_r + 2'b01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts and reset requests
    // ------------------------------------------------------------------
    // Non-maskable: no master-flag input gates these. Each new event is
    // presented at once; a depth count holds the preempted ones pending.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            watchdog_irq   <= 1'b0;
            fetch_trap_irq <= 1'b0;
            wd_pend_r      <= 8'h00;
            at_pend_r      <= 8'h00;
            ovf_seen_r     <= 1'b0;
            trap_seen_r    <= 1'b0;
        end else if (ce) begin
            ovf_seen_r  <= ovf;
            trap_seen_r <= trap;
            watchdog_irq   <= ovf && !out_r; // R4 R5 R6
            fetch_trap_irq <= trap && !trap_action_select_r; // R14 R16 R17
            if (ovf && !out_r && !(irq_ack && wd_pend_r != 8'h00)) begin
                wd_pend_r <= wd_pend_r + 8'h01; // R6
            end else if (irq_ack && wd_pend_r != 8'h00 && !(ovf && !out_r)) begin
                wd_pend_r <= wd_pend_r - 8'h01;
            end
            if (trap && !trap_action_select_r && !(irq_ack && at_pend_r != 8'h00)) begin
                at_pend_r <= at_pend_r + 8'h01; // R17
            end else if (irq_ack && at_pend_r != 8'h00 && !(trap && !trap_action_select_r)) begin
                at_pend_r <= at_pend_r - 8'h01;
            end
        end
    end

    // Reset pulse: 24 cycles, reloaded by an overflow with out_r set or a trap with trap action 1 that comes while it stands
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_cnt_r    <= 5'd0;
            hw_reset_req <= 1'b0;
            osc_restart  <= 1'b0;
        end else if (ce) begin
            if ((ovf && out_r) || (trap && trap_action_select_r)) begin // R8 R15
                rst_cnt_r    <= 5'd23; // R9 R18
                hw_reset_req <= 1'b1;
                osc_restart  <= low_speed_mode_one; // R10
            end else if (rst_cnt_r != 5'd0) begin
                rst_cnt_r <= rst_cnt_r - 5'd1;
            end else begin
                hw_reset_req <= 1'b0;
                osc_restart  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    // Control and command are write-only and read zero
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            apb_done_r <= 1'b0;
        end else if (ce) begin
            pready     <= setup;
            apb_done_r <= setup;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            if (setup) begin
                case (paddr)
                    `WDAT_OFF_CTRL: ;
                    `WDAT_OFF_CMD:  ;
                    `WDAT_OFF_STAT: prdata <= {22'h0, hw_reset_req, wd_pend_r != 8'h00,
                                               at_pend_r != 8'h00, ram_trap_select_r, en_r, out_r,
                                               bin_r, tt_r};
                    `WDAT_OFF_AREA: prdata <= {16'h0, SFR_HI};
                    default:        pslverr <= 1'b1;
                endcase
            end
            if (!psel) begin
                apb_done_r <= 1'b0;
            end
        end
    end

endmodule // wdat_top

// File: wdat_trap_cmp.v
/*
 * Fetch-address window compare: flags a fetch whose address lies
 * inside [lo, hi]. Assumes inclusive bounds and synchronous inputs.
 */
`timescale 1ns/1ps

module wdat_trap_cmp #(
    parameter AW = 16
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire          ce,
    input  wire          on,
    input  wire [AW-1:0] addr,
    input  wire [AW-1:0] lo,
    input  wire [AW-1:0] hi,
    output reg           hit_r
);

    // Registered hit keeps the compare off the fetch path
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hit_r <= 1'b0;
        end else if (ce) begin
            hit_r <= on && (addr >= lo) && (addr <= hi);
        end
    end

endmodule // wdat_trap_cmp
